// ---- rtl/hv_prog_pkg.sv ----
// constants and types for the parallel high-voltage programming port
`default_nettype none
package hv_prog_pkg;
   // ---------------------------------------------------------------
   // pin group
   // ---------------------------------------------------------------
   typedef struct packed {
      logic action_select_hi;
      logic action_select_lo;
      logic byte_select_one;
      logic byte_select_two;
      logic page_load_strobe;
      logic load_clock_input;
      logic write_strobe_n;
      logic output_enable_n;
   } prog_pins_t;

   typedef enum logic {ST_READY, ST_BUSY} prog_state_t;

   // ---------------------------------------------------------------
   // action select and command codes
   // ---------------------------------------------------------------
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK = 8'h20;
   localparam logic [7:0] CMD_RD_ID = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

   // ---------------------------------------------------------------
   // byte select pairs {two, one}
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_LOCK = 2'h1;
   localparam logic [1:0] SEL_EXT = 2'h2;
   localparam logic [1:0] SEL_HIGH = 2'h3;

   // ---------------------------------------------------------------
   // geometry, reset values, timing
   // ---------------------------------------------------------------
   localparam int FLASH_AW_DEF = 12;
   localparam int FLASH_PAGE_BITS_DEF = 5;
   localparam int EE_AW_DEF = 6;
   localparam int EE_PAGE_BITS_DEF = 2;
   localparam int WRITE_CYCLES_DEF = 64;
   localparam logic [15:0] PIN_IDLE = 16'h03FF;
   localparam logic [7:0] BYTE_ERASED = 8'hFF;
   localparam logic [1:0] LOCK_RESET = 2'h3;
   localparam logic [1:0] LOCK_MODE3 = 2'h0;
   localparam logic [7:0] LOCK_PAD = 8'hFC;
endpackage
`default_nettype wire

// ---- rtl/hv_prog_port.sv ----
// parallel high-voltage programming port: loads, page buffers, memories
`default_nettype none
// Behaviour
// (R1) command loaded by load clock, select 10
// (R2) 0x10 prepares flash page writing
// (R3) select 00, one low loads address low
// (R4) select 00, one high loads address high
// (R5) select 01 loads data low or high
// (R6) page strobe, one high latches flash word
// (R7) low bits word, high bits page
// (R8) write strobe falls: page programs, busy low
// (R9) programmer waits for ready before next page
// (R10) command 0x00 ends page programming
// (R11) 0x11 eeprom page write, one low
// (R12) 0x02 reads flash byte per one
// (R13) 0x03 reads eeprom byte, one low
// (R14) 0x40 writes fuse byte, 0 programs
// (R15) byte selects pick low, high, extended fuse
// (R16) 0x20 programs lock bits; mode 3 refuses
// (R17) lock bits never return unprogrammed here
// (R18) 0x04 reads fuses and lock per selects
// (R19) 0x08 reads identification byte 0..2
// (R20) 0x08, address 0, one high: calibration
// (R21) bus driven only while output enable low
// (R22) ready low while programming, high otherwise
// (R23) select 11 makes load clock do nothing
// (R24) command and address held during programming; load edges here still reload them while busy
module hv_prog_port
   import hv_prog_pkg::*;
#(
   parameter int FLASH_AW = FLASH_AW_DEF,
   parameter int PAGE_BITS = FLASH_PAGE_BITS_DEF,
   parameter int EE_AW = EE_AW_DEF,
   parameter int EE_PAGE_BITS = EE_PAGE_BITS_DEF,
   parameter int WRITE_CYCLES = WRITE_CYCLES_DEF,
   // identification and calibration values are arbitrary
   parameter logic [23:0] ID_BYTES = 24'h030201,
   parameter logic [7:0] CALIB_BYTE = 8'h80,
   parameter logic [7:0] FUSE_LOW_INIT = 8'hFF,
   parameter logic [7:0] FUSE_HIGH_INIT = 8'hFF,
   parameter logic [7:0] FUSE_EXT_INIT = 8'hFF
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire prog_pins_t prog_pins,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy_out
);
   localparam int PAGE_WORDS = 1 << PAGE_BITS;
   localparam int EE_PAGE = 1 << EE_PAGE_BITS;
   localparam int BUSY_MAX = WRITE_CYCLES + 2;

   // ---------------------------------------------------------------
   // pin synchronisers: a change counts once stages two and three agree
   // ---------------------------------------------------------------
   logic [15:0] sync1;
   logic [15:0] sync2;
   logic [15:0] sync3;
   logic [15:0] filt;
   logic [15:0] prev;
   logic [15:0] agree;
   prog_pins_t fpins;
   prog_pins_t ppins;
   logic [7:0] fdata;

   assign agree = ~(sync2 ^ sync3);
   assign fpins = prog_pins_t'(filt[15:8]);
   assign ppins = prog_pins_t'(prev[15:8]);
   assign fdata = filt[7:0];

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1 <= PIN_IDLE;
         sync2 <= PIN_IDLE;
         sync3 <= PIN_IDLE;
         filt <= PIN_IDLE;
         prev <= PIN_IDLE;
      end else begin
         sync1 <= {prog_pins, data_in};
         sync2 <= sync1;
         sync3 <= sync2;
         filt <= (filt & ~agree) | (sync3 & agree);
         prev <= filt;
      end
   end

   logic load_edge;
   logic page_edge;
   logic write_fall;
   logic [1:0] action;
   logic [1:0] sel;

   assign load_edge = fpins.load_clock_input & ~ppins.load_clock_input;
   assign page_edge = fpins.page_load_strobe & ~ppins.page_load_strobe;
   assign write_fall = ppins.write_strobe_n & ~fpins.write_strobe_n;
   assign action = {fpins.action_select_hi, fpins.action_select_lo};
   assign sel = {fpins.byte_select_two, fpins.byte_select_one};

   // ---------------------------------------------------------------
   // command, address and data loading
   // ---------------------------------------------------------------
   logic [7:0] cmd;
   logic [7:0] addr_lo;
   logic [7:0] addr_hi;
   logic [7:0] data_lo;
   logic [7:0] data_hi;

   // load registers are only touched by reset and load edges, never by writes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cmd <= CMD_NOP;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         data_lo <= BYTE_ERASED;
         data_hi <= BYTE_ERASED;
      end else if (load_edge) begin // see (R24)
         if (action == ACT_CMD) begin
            cmd <= fdata; // see (R1) see (R2) see (R10)
         end else if (action == ACT_ADDR && !fpins.byte_select_one) begin
            addr_lo <= fdata; // see (R3)
         end else if (action == ACT_ADDR) begin
            addr_hi <= fdata; // see (R4)
         end else if (action == ACT_DATA && !fpins.byte_select_one) begin
            data_lo <= fdata; // see (R5)
         end else if (action == ACT_DATA) begin
            data_hi <= fdata;
         end
      end // select 11 falls through untouched, see (R23)
   end

   logic [15:0] full_addr;
   logic [FLASH_AW-1:0] faddr;
   logic [EE_AW-1:0] eaddr;
   logic [FLASH_AW-PAGE_BITS-1:0] page_index_bits;
   logic [PAGE_BITS-1:0] word_in_page_bits;

   assign full_addr = {addr_hi, addr_lo};
   assign faddr = full_addr[FLASH_AW-1:0];
   assign eaddr = full_addr[EE_AW-1:0];
   assign page_index_bits = faddr[FLASH_AW-1:PAGE_BITS]; // see (R7)
   assign word_in_page_bits = faddr[PAGE_BITS-1:0];

   // ---------------------------------------------------------------
   // page buffers
   // ---------------------------------------------------------------
   logic [15:0] page_buf [PAGE_WORDS];
   logic [7:0] ee_buf [EE_PAGE];

   always_ff @(posedge ref_clk) begin
      if (page_edge && cmd == CMD_WR_FLASH && fpins.byte_select_one) begin
         page_buf[word_in_page_bits] <= {data_hi, data_lo}; // see (R6)
      end
   end

   always_ff @(posedge ref_clk) begin
      if (page_edge && cmd == CMD_WR_EEPROM) begin
         ee_buf[eaddr[EE_PAGE_BITS-1:0]] <= data_lo; // see (R11)
      end
   end

   // ---------------------------------------------------------------
   // write start decode and ready/busy
   // ---------------------------------------------------------------
   prog_state_t state;
   logic [15:0] busy_cnt;
   logic [1:0] lock;
   logic lock_open;
   logic go_flash;
   logic go_ee;
   logic go_fuse;
   logic go_lock;
   logic go;

   assign lock_open = (lock != LOCK_MODE3);
   assign go_flash = cmd == CMD_WR_FLASH; // see (R8)
   assign go_ee = cmd == CMD_WR_EEPROM && !fpins.byte_select_one;
   assign go_fuse = cmd == CMD_WR_FUSE && sel != SEL_HIGH; // see (R14)
   assign go_lock = cmd == CMD_WR_LOCK && lock_open; // see (R16)
   assign go = write_fall && state == ST_READY
      && (go_flash || go_ee || go_fuse || go_lock);
   assign ready_busy_out = (state == ST_READY); // see (R22)

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= ST_READY;
         busy_cnt <= 16'h0000;
      end else begin
         case (state)
            ST_READY: begin
               busy_cnt <= 16'h0000;
               if (go) begin
                  state <= ST_BUSY; // see (R8) see (R11)
               end
            end
            ST_BUSY: begin
               busy_cnt <= busy_cnt + 16'h0001;
               if (busy_cnt == 16'(WRITE_CYCLES - 1)) begin
                  state <= ST_READY;
               end
            end
            default: state <= ST_READY;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // memories: pages committed when programming starts
   // ---------------------------------------------------------------
   logic [15:0] flash [1 << FLASH_AW];
   logic [7:0] eeprom [1 << EE_AW];

   always_ff @(posedge ref_clk) begin
      if (go && go_flash) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            flash[{page_index_bits, PAGE_BITS'(i)}] <= page_buf[i]; // see (R7)
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (go && go_ee) begin
         for (int i = 0; i < EE_PAGE; i++) begin
            eeprom[{eaddr[EE_AW-1:EE_PAGE_BITS], EE_PAGE_BITS'(i)}] <= ee_buf[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // fuses and lock bits
   // ---------------------------------------------------------------
   logic [7:0] fuse_low;
   logic [7:0] fuse_high;
   logic [7:0] fuse_ext;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fuse_low <= FUSE_LOW_INIT;
         fuse_high <= FUSE_HIGH_INIT;
         fuse_ext <= FUSE_EXT_INIT;
      end else if (go && go_fuse) begin
         if (sel == SEL_LOW) begin
            fuse_low <= data_lo; // see (R15)
         end else if (sel == SEL_LOCK) begin
            fuse_high <= data_lo;
         end else begin
            fuse_ext <= data_lo;
         end
      end
   end

   // only ever clears bits; only reset sets them back to LOCK_RESET
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lock <= LOCK_RESET;
      end else if (go && go_lock) begin
         lock <= lock & data_lo[1:0]; // see (R16) see (R17)
      end
   end

   // ---------------------------------------------------------------
   // read-back onto the data bus
   // ---------------------------------------------------------------
   logic [7:0] next_dout;
   logic [15:0] fword;

   assign fword = flash[faddr];

   always_comb begin
      next_dout = BYTE_ERASED;
      if (cmd == CMD_RD_FLASH) begin
         next_dout = fpins.byte_select_one ? fword[15:8] : fword[7:0]; // see (R12)
      end else if (cmd == CMD_RD_EEPROM && !fpins.byte_select_one) begin
         next_dout = eeprom[eaddr]; // see (R13)
      end else if (cmd == CMD_RD_FUSE) begin
         case (sel) // see (R18)
            SEL_LOW: next_dout = fuse_low;
            SEL_HIGH: next_dout = fuse_high;
            SEL_EXT: next_dout = fuse_ext;
            default: next_dout = LOCK_PAD | {6'h00, lock};
         endcase
      end else if (cmd == CMD_RD_ID) begin
         if (fpins.byte_select_one) begin
            if (addr_lo == 8'h00) begin
               next_dout = CALIB_BYTE; // see (R20)
            end
         end else if (addr_lo == 8'h00) begin
            next_dout = ID_BYTES[7:0]; // see (R19)
         end else if (addr_lo == 8'h01) begin
            next_dout = ID_BYTES[15:8];
         end else if (addr_lo == 8'h02) begin
            next_dout = ID_BYTES[23:16];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         data_out <= BYTE_ERASED;
         data_oe <= 1'b0;
      end else begin
         data_out <= next_dout;
         data_oe <= ~fpins.output_enable_n; // see (R21)
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_write_start;
      write_fall && ready_busy_out && (go_flash || go_ee);
   endsequence

   sequence s_busy_window;
      !ready_busy_out ##[1:BUSY_MAX] ready_busy_out;
   endsequence

   a_cmd_load: assert property ( // see (R1)
      load_edge && action == ACT_CMD |=> cmd == $past(fdata))
      else $error("command not loaded");
   a_addr_low: assert property ( // see (R3)
      load_edge && action == ACT_ADDR && !fpins.byte_select_one
      |=> addr_lo == $past(fdata) && $stable(addr_hi))
      else $error("address low not loaded");
   a_addr_high: assert property ( // see (R4)
      load_edge && action == ACT_ADDR && fpins.byte_select_one
      |=> addr_hi == $past(fdata) && $stable(addr_lo))
      else $error("address high not loaded");
   a_data_load: assert property ( // see (R5)
      load_edge && action == ACT_DATA
      |=> ($past(fpins.byte_select_one) ? data_hi : data_lo) == $past(fdata))
      else $error("data byte not loaded");
   a_idle_action: assert property ( // see (R23)
      load_edge && action == 2'h3
      |=> $stable(cmd) && $stable(full_addr) && $stable({data_hi, data_lo}))
      else $error("idle action changed state");
   a_page_busy: assert property (s_write_start |=> s_busy_window) // see (R8)
      else $error("busy window wrong");
   a_nop_no_write: assert property ( // see (R10)
      write_fall && ready_busy_out && cmd == CMD_NOP |=> ready_busy_out)
      else $error("nop started a write");
   a_lock_mode3: assert property ( // see (R16)
      write_fall && ready_busy_out && cmd == CMD_WR_LOCK && lock == LOCK_MODE3
      |=> ready_busy_out && lock == LOCK_MODE3)
      else $error("locked device accepted lock write");
   a_lock_no_erase: assert property ( // see (R17)
      ##1 (lock & ~$past(lock)) == 2'h0)
      else $error("lock bit returned unprogrammed");
   a_bus_drive: assert property ( // see (R21)
      ##1 data_oe == !$past(fpins.output_enable_n))
      else $error("bus driven outside output enable");
   a_flash_read: assert property ( // see (R12)
      cmd == CMD_RD_FLASH && !fpins.byte_select_one |=> data_out == $past(fword[7:0]))
      else $error("flash low byte read wrong");
endmodule
`default_nettype wire

// ---- test/prog_model.sv ----
// programmer model: drives strobes, selects and the data bus
`default_nettype none
module prog_model
   import hv_prog_pkg::*;
(
   input wire logic ref_clk,
   input wire logic ready_busy_out,
   input wire logic [7:0] bus,
   output var prog_pins_t pins,
   output logic [7:0] drv_data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pins = prog_pins_t'(8'h03);
      drv_data = 8'hFF;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // every level held 7 cycles, three more than the four-cycle pin filter delay
   task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
      pins.action_select_hi = act[1];
      pins.action_select_lo = act[0];
      pins.byte_select_one = bs1;
      drv_data = val;
      wait_n(7);
      pins.load_clock_input = 1'b1;
      wait_n(7);
      pins.load_clock_input = 1'b0;
      wait_n(7);
   endtask

   task automatic latch();
      pins.byte_select_one = 1'b1;
      wait_n(7);
      pins.page_load_strobe = 1'b1;
      wait_n(7);
      pins.page_load_strobe = 1'b0;
      wait_n(7);
   endtask

   // counts busy cycles, then waits out the operation
   task automatic write(input logic bs1, input logic bs2, output int busy);
      int k;
      busy = 0;
      pins.byte_select_one = bs1;
      pins.byte_select_two = bs2;
      wait_n(7);
      pins.write_strobe_n = 1'b0;
      for (k = 0; k < 60; k++) begin
         wait_n(1);
         if (k == 6) pins.write_strobe_n = 1'b1;
         if (ready_busy_out === 1'b0) busy++;
      end
   endtask

   task automatic read(input logic bs1, input logic bs2, output logic [7:0] val);
      pins.byte_select_one = bs1;
      pins.byte_select_two = bs2;
      pins.output_enable_n = 1'b0;
      wait_n(7);
      val = bus;
      pins.output_enable_n = 1'b1;
      wait_n(7);
   endtask
endmodule
`default_nettype wire

// ---- test/test_hv_prog_port.sv ----
// self-checking bench for the parallel programming port
`default_nettype none
module test_hv_prog_port
   import hv_prog_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WCYC = 8;
   // arbitrary identification and calibration values
   localparam logic [23:0] ID_VAL = 24'h5A3C96;
   localparam logic [7:0] CAL_VAL = 8'h4E;
   logic ref_clk, srst, data_oe, ready_busy_out;
   prog_pins_t prog_pins;
   logic [7:0] data_in, data_out, drv_data, rd, ahi, pg;
   logic [7:0] wlo [8], whi [8], wad [8], fuse [3], ee [4];
   logic [7:0] lock_val [3] = '{8'hFE, 8'hFD, 8'hFF};
   logic [1:0] lock;
   int err_count, comparisons, busy;

   // with output enable low and the port not yet driving, the bus shows the inverse of the programmer byte
   assign data_in = data_oe ? data_out :
      (prog_pins.output_enable_n ? drv_data : ~drv_data);

   hv_prog_port #(.WRITE_CYCLES(WCYC), .ID_BYTES(ID_VAL), .CALIB_BYTE(CAL_VAL)) dut (
      .ref_clk(ref_clk), .srst(srst), .prog_pins(prog_pins), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .ready_busy_out(ready_busy_out));
   prog_model pm (.ref_clk(ref_clk), .ready_busy_out(ready_busy_out), .bus(data_in),
      .pins(prog_pins), .drv_data(drv_data));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_count(input string what, input int exp, input int got);
      comparisons++;
      if (got != exp) begin
         err_count++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] fuse_exp(input logic [1:0] sel);
      case (sel)
         SEL_LOW: return fuse[0];
         SEL_HIGH: return fuse[1];
         SEL_EXT: return fuse[2];
         default: return LOCK_PAD | {6'h00, lock};
      endcase
   endfunction

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      err_count = 0;
      comparisons = 0;
      srst = 1'b1;
      void'($urandom(32'h84461d61));
      repeat (12) @(posedge ref_clk);
      #1 srst = 1'b0;
      pm.wait_n(1);
      check_byte("ready", 8'h01, {7'h00, ready_busy_out});
      check_byte("bus enable", 8'h00, {7'h00, data_oe});
      ahi = 8'($urandom % 16);
      pg = 8'($urandom % 8);
      pm.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
      for (int i = 0; i < 8; i++) begin
         wad[i] = {pg[2:0], 5'(i == 0 ? 0 : i == 7 ? 31 : i * 4 + $urandom % 4)};
         wlo[i] = 8'($urandom);
         whi[i] = 8'($urandom);
         pm.load(ACT_ADDR, 1'b0, wad[i]);
         pm.load(ACT_DATA, 1'b0, wlo[i]);
         pm.load(ACT_DATA, 1'b1, whi[i]);
         pm.load(2'h3, 1'b1, ~whi[i]);
         pm.latch();
      end
      pm.load(ACT_ADDR, 1'b1, ahi);
      pm.write(1'b0, 1'b0, busy);
      check_count("flash busy", WCYC, busy);
      pm.load(ACT_CMD, 1'b0, CMD_NOP);
      pm.write(1'b0, 1'b0, busy);
      check_count("busy under nop", 0, busy);
      pm.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
      pm.load(ACT_ADDR, 1'b1, ahi);
      for (int i = 0; i < 8; i++) begin
         pm.load(ACT_ADDR, 1'b0, wad[i]);
         pm.read(1'b0, 1'b0, rd);
         check_byte("flash low", wlo[i], rd);
         pm.read(1'b1, 1'b0, rd);
         check_byte("flash high", whi[i], rd);
         check_byte("bus released", 8'h00, {7'h00, data_oe});
      end
      $display("test flash done");
      pg = 8'($urandom % 16);
      pm.load(ACT_CMD, 1'b0, CMD_WR_EEPROM);
      pm.load(ACT_ADDR, 1'b1, 8'h00);
      for (int b = 0; b < 4; b++) begin
         ee[b] = 8'($urandom);
         pm.load(ACT_ADDR, 1'b0, {2'h0, pg[3:0], 2'(b)});
         pm.load(ACT_DATA, 1'b0, ee[b]);
         pm.latch();
      end
      pm.write(1'b0, 1'b0, busy);
      check_count("eeprom busy", WCYC, busy);
      pm.load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
      for (int b = 0; b < 4; b++) begin
         pm.load(ACT_ADDR, 1'b0, {2'h0, pg[3:0], 2'(b)});
         pm.read(1'b0, 1'b0, rd);
         check_byte("eeprom byte", ee[b], rd);
      end
      $display("test eeprom done");
      pm.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
      for (int s = 0; s < 3; s++) begin
         fuse[s] = 8'($urandom);
         pm.load(ACT_DATA, 1'b0, fuse[s]);
         pm.write(s == 1, s == 2, busy);
         check_count("fuse busy", WCYC, busy);
      end
      pm.write(1'b1, 1'b1, busy);
      check_count("fuse both selects", 0, busy);
      lock = LOCK_RESET;
      pm.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
      for (int j = 0; j < 3; j++) begin
         pm.load(ACT_DATA, 1'b0, lock_val[j]);
         pm.write(1'b0, 1'b0, busy);
         check_count("lock busy", lock == LOCK_MODE3 ? 0 : WCYC, busy);
         if (lock != LOCK_MODE3) lock = lock & lock_val[j][1:0];
      end
      pm.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
      for (int s = 0; s < 4; s++) begin
         pm.read(s[0], s[1], rd);
         check_byte("fuse or lock", fuse_exp(2'(s)), rd);
      end
      $display("test fuse and lock done");
      pm.load(ACT_CMD, 1'b0, CMD_RD_ID);
      for (int a = 0; a < 3; a++) begin
         pm.load(ACT_ADDR, 1'b0, 8'(a));
         pm.read(1'b0, 1'b0, rd);
         check_byte("id byte", 8'(ID_VAL >> (8 * a)), rd);
      end
      pm.load(ACT_ADDR, 1'b0, 8'h00);
      pm.read(1'b1, 1'b0, rd);
      check_byte("calibration", CAL_VAL, rd);
      $display("test identification done");
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      $display("[ERR] run length expected finish seen timeout");
      give_verdict();
   end
endmodule
`default_nettype wire
